/* File: rtl/tmz_pkg.sv */
// timer0 block constants, register map and field layout
package tmz_pkg;
    // register indexes (byte address = index * 4)
    localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
    localparam logic [7:0] IDX_INT_CONTROL = 8'h0b;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_PORT_A_DIR = 8'h85;
    localparam logic [7:0] IDX_CONTROL = 8'hc0;
    // option register fields
    localparam int OPT_CLOCK_SOURCE_SELECT = 5;
    localparam int OPT_SOURCE_EDGE_SELECT = 4;
    localparam int OPT_PRESCALER_ASSIGN = 3;
    localparam int OPT_RATIO_LSB = 0;
    // interrupt control fields
    localparam int INTC_OVERFLOW_INT_ENABLE = 5;
    localparam int INTC_OVERFLOW_FLAG = 2;
    // control register fields
    localparam int CTL_SLEEP = 0;
    localparam int CTL_WATCHDOG_CLEAR = 1;
    // reset values
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [7:0] RST_INT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIR = 8'h1f;
    localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
    localparam logic [4:0] PORT_A_DIR_MASK = 5'h1f;
    // oscillator period per phase and cycle counts
    localparam int CLK_PERIOD_NS = 5;
    localparam int TOSC_NS = 5;
    localparam int TOSC_CYCLES = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASES_PER_INSTR = 4;
    localparam int WRITE_HOLD_INSTR = 2;
    localparam int ROLL_DELAY_TOSC = 3;
    localparam int ROLL_DELAY_CYCLES = ROLL_DELAY_TOSC * TOSC_CYCLES;
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } tmz_phase_type;
endpackage : tmz_pkg

/* File: rtl/tmz_timer0.sv */
// timer0 with shared prescaler, wishbone register slave
// Functional notes
// RULE1 - clock source select clear: count one per instruction cycle, no prescaler
// RULE2 - after a timer write, hold increments for two instruction cycles
// RULE3 - source select set: count external edges; edge bit 0 rising, 1 falling
// RULE4 - assign bit clear routes prescaler to timer, set routes it to watchdog
// RULE5 - prescaled timer ratios range from 1:2 to 1:256
// RULE6 - overflow flag set when count wraps from ff to 00
// RULE7 - interrupt request only while overflow interrupt enable is set
// RULE8 - hardware never clears the overflow flag; software does
// RULE9 - timer stopped during sleep, so overflow cannot wake
// RULE10 - wrap sets flag at once; count shows roll-over three periods later
// RULE11 - prescaler output sampled in second and fourth phases
// RULE12 - unscaled external input high and low at least two periods
// RULE13 - prescaled external input period at least four periods over ratio
// RULE14 - external input divided by ripple counter ahead of synchronizer; here the pin is synchronized first, then fed to the prescaler
// RULE15 - short delay from external edge to increment from synchronization
// RULE16 - one 8-bit prescaler counter, used by timer or watchdog only
// RULE17 - timer write clears prescaler when assigned to timer
// RULE18 - watchdog clear clears prescaler when assigned to watchdog
// RULE19 - prescaler value is not readable or writable
// RULE20 - before moving prescaler to watchdog, clear timer and watchdog first
// RULE21 - before moving prescaler to timer, clear watchdog and prescaler first
// RULE22 - ratio field value n gives division by two to the n plus one
// RULE23 - timer count readable anytime; write replaces count immediately
module tmz_timer0 (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [9:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic EXT_COUNT_I,
    input wire logic WATCHDOG_CLEAR_I,
    output logic TIMER_IRQ_O,
    output logic PRESCALER_TICK_WDT_O,
    output logic [7:0] OPTION_O,
    output logic [4:0] PORT_A_DIR_O
);
    logic [7:0] timer_count_r;
    logic [7:0] option_r;
    logic [7:0] int_control_r;
    logic [4:0] port_a_dir_r;
    logic sleep_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [1:0] phase_r;
    logic [1:0] hold_r;
    logic [7:0] presc_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_prev_r;
    logic samp_r;
    logic samp_prev_r;
    logic [1:0] roll_r;
    logic wdt_clear_s1_r;
    logic wdt_clear_s2_r;
    logic wdt_clear_prev_r;

    logic bus_req;
    logic bus_wr;
    logic [7:0] idx;
    logic wr_timer;
    logic wr_option;
    logic wr_intc;
    logic wr_ctl;
    logic wr_dir;
    logic assigned_timer;
    logic ext_mode;
    logic ext_edge;
    logic src_edge;
    logic presc_clk_en;
    logic presc_clr;
    logic [2:0] ratio;
    logic [7:0] ratio_mask;
    logic presc_out;
    logic tick_src;
    logic timer_tick;
    logic instr_end;
    logic wrap;
    logic wdt_clear_pulse;

    assign bus_req = CYC_I & STB_I & ~ack_r;
    assign bus_wr = bus_req & WE_I & SEL_I[0];
    assign idx = ADR_I[9:2];
    assign wr_timer = bus_wr & (idx == tmz_pkg::IDX_TIMER_COUNT);
    assign wr_option = bus_wr & (idx == tmz_pkg::IDX_OPTION);
    assign wr_intc = bus_wr & (idx == tmz_pkg::IDX_INT_CONTROL);
    assign wr_ctl = bus_wr & (idx == tmz_pkg::IDX_CONTROL);
    assign wr_dir = bus_wr & (idx == tmz_pkg::IDX_PORT_A_DIR);

    assign assigned_timer = ~option_r[tmz_pkg::OPT_PRESCALER_ASSIGN]; // RULE4
    assign ext_mode = option_r[tmz_pkg::OPT_CLOCK_SOURCE_SELECT];
    assign ratio = option_r[tmz_pkg::OPT_RATIO_LSB +: 3];
    assign instr_end = (phase_r == 2'(tmz_pkg::PH_Q4));

    // chosen edge of the synchronized pin; edge bit 1 picks falling
    assign ext_edge = option_r[tmz_pkg::OPT_SOURCE_EDGE_SELECT] ?
        (ext_prev_r & ~ext_s2_r) : (~ext_prev_r & ext_s2_r); // RULE3

    // source feeding the timer or its prescaler: external edges or instruction cycles
    assign src_edge = ext_mode ? ext_edge : instr_end; // RULE1 RULE3

    // watchdog clear from software or the watchdog clear pin
    assign wdt_clear_pulse = (wdt_clear_s2_r & ~wdt_clear_prev_r) |
        (wr_ctl & DAT_I[tmz_pkg::CTL_WATCHDOG_CLEAR]);

    // watchdog side clocks the prescaler with its own tick, modelled as
    // instruction end; timer side uses the selected source
    assign presc_clk_en = sleep_r ? 1'b0 :
        (assigned_timer ? src_edge : instr_end); // RULE9 RULE16
    assign presc_clr = (assigned_timer & wr_timer) |
        (~assigned_timer & wdt_clear_pulse); // RULE17 RULE18

    // divided output bit: bit n of the counter toggles every 2^n inputs,
    // so its falling edge marks division by 2^(n+1), symmetric
    assign presc_out = presc_r[ratio]; // RULE14 RULE22 RULE5
    // low ratio+1 bits all set marks the watchdog's terminal count
    assign ratio_mask = 8'hff >> (3'd7 - ratio); // RULE22

    // the sampled pair moves only every second clock; taking the fall in
    // the clock right after a sample keeps it from counting twice
    assign tick_src = assigned_timer ?
        (samp_prev_r & ~samp_r & ~phase_r[0]) : src_edge; // RULE4 RULE15
    assign timer_tick = tick_src & ~sleep_r & (hold_r == 2'd0); // RULE9 RULE2
    assign wrap = timer_tick & (timer_count_r == 8'hff); // RULE6

    // instruction phase counter, one phase per oscillator period
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            phase_r <= 2'(tmz_pkg::PH_Q1);
        end else begin
            phase_r <= phase_r + 2'd1;
        end
    end

    // two-flop synchronizers for pins
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_prev_r <= 1'b0;
            wdt_clear_s1_r <= 1'b0;
            wdt_clear_s2_r <= 1'b0;
            wdt_clear_prev_r <= 1'b0;
        end else begin
            ext_s1_r <= EXT_COUNT_I;
            ext_s2_r <= ext_s1_r; // RULE12 RULE13
            ext_prev_r <= ext_s2_r;
            wdt_clear_s1_r <= WATCHDOG_CLEAR_I;
            wdt_clear_s2_r <= wdt_clear_s1_r;
            wdt_clear_prev_r <= wdt_clear_s2_r;
        end
    end

    // single 8-bit prescaler, never visible on the bus
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            presc_r <= 8'h00;
        end else if (presc_clr) begin
            presc_r <= 8'h00; // RULE17 RULE18 RULE19
        end else if (presc_clk_en) begin
            presc_r <= presc_r + 8'h01; // RULE16
        end
    end

    // prescaler output sampled only in the second and fourth phases
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            samp_r <= 1'b0;
            samp_prev_r <= 1'b0;
        end else if (phase_r == 2'(tmz_pkg::PH_Q2) ||
                     phase_r == 2'(tmz_pkg::PH_Q4)) begin
            samp_r <= presc_out; // RULE11
            samp_prev_r <= samp_r;
        end
    end

    // increment hold after a write, counted in instruction cycles
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            hold_r <= 2'd0;
        end else if (wr_timer) begin
            hold_r <= 2'(tmz_pkg::WRITE_HOLD_INSTR); // RULE2
        end else if (instr_end && hold_r != 2'd0) begin
            hold_r <= hold_r - 2'd1;
        end
    end

    // the counter shows ff until the roll-over lands three periods later
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            roll_r <= 2'd0;
        end else if (wr_timer) begin
            roll_r <= 2'd0;
        end else if (wrap) begin
            roll_r <= 2'(tmz_pkg::ROLL_DELAY_CYCLES); // RULE10
        end else if (roll_r != 2'd0) begin
            roll_r <= roll_r - 2'd1;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            timer_count_r <= tmz_pkg::RST_TIMER_COUNT;
        end else if (wr_timer) begin
            timer_count_r <= DAT_I[7:0]; // RULE23
        end else if (roll_r == 2'd1) begin
            timer_count_r <= 8'h00; // RULE10
        end else if (timer_tick && !wrap && roll_r == 2'd0) begin
            timer_count_r <= timer_count_r + 8'h01; // RULE1
        end
    end

    // ticks arriving during the roll-over window are absorbed; at the
    // shortest input spacing this cannot happen

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            option_r <= tmz_pkg::RST_OPTION;
            port_a_dir_r <= tmz_pkg::RST_PORT_A_DIR[4:0];
            sleep_r <= 1'b0;
        end else begin
            if (wr_option) begin
                option_r <= DAT_I[7:0]; // RULE4
            end
            if (wr_dir) begin
                port_a_dir_r <= DAT_I[4:0] & tmz_pkg::PORT_A_DIR_MASK;
            end
            if (wr_ctl) begin
                sleep_r <= DAT_I[tmz_pkg::CTL_SLEEP]; // RULE9
            end
        end
    end

    // interrupt control; the flag is set by hardware or by a software write, set beats clear
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            int_control_r <= tmz_pkg::RST_INT_CONTROL;
        end else begin
            if (wr_intc) begin
                int_control_r <= DAT_I[7:0];
            end
            if (wrap) begin
                int_control_r[tmz_pkg::INTC_OVERFLOW_FLAG] <= 1'b1; // RULE6 RULE8
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            TIMER_IRQ_O <= 1'b0;
            PRESCALER_TICK_WDT_O <= 1'b0;
            OPTION_O <= tmz_pkg::RST_OPTION;
            PORT_A_DIR_O <= tmz_pkg::RST_PORT_A_DIR[4:0];
        end else begin
            TIMER_IRQ_O <= int_control_r[tmz_pkg::INTC_OVERFLOW_FLAG] &
                int_control_r[tmz_pkg::INTC_OVERFLOW_INT_ENABLE]; // RULE7
            PRESCALER_TICK_WDT_O <= ~assigned_timer & presc_clk_en &
                ((presc_r & ratio_mask) == ratio_mask); // RULE4
            OPTION_O <= option_r;
            PORT_A_DIR_O <= port_a_dir_r;
        end
    end

    // wishbone slave: one wait state, unmapped reads return zero
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req;
            if (bus_req && !WE_I) begin
                case (idx)
                    tmz_pkg::IDX_TIMER_COUNT: dat_r <= {24'h0, timer_count_r};
                    tmz_pkg::IDX_INT_CONTROL: dat_r <= {24'h0, int_control_r};
                    tmz_pkg::IDX_OPTION: dat_r <= {24'h0, option_r};
                    tmz_pkg::IDX_PORT_A_DIR: dat_r <= {27'h0, port_a_dir_r};
                    tmz_pkg::IDX_CONTROL: dat_r <= {31'h0, sleep_r};
                    default: dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign ACK_O = ack_r;
    assign DAT_O = dat_r;

    property p_flag_on_wrap;
        @(posedge MCLK_I) disable iff (RST_I)
        wrap |=> int_control_r[tmz_pkg::INTC_OVERFLOW_FLAG];
    endproperty
    a_flag_on_wrap: assert property (p_flag_on_wrap) // RULE6
        else $error("overflow flag not set on wrap");

    // a wrap that no timer write overrides while the roll-over is pending
    sequence s_wrap_quiet;
        (wrap && !wr_timer) ##1 !wr_timer [*3];
    endsequence
    // count still shows ff, then the roll-over lands
    sequence s_roll_shown;
        (timer_count_r == 8'hff) ##1 (timer_count_r == 8'h00);
    endsequence
    property p_roll_late;
        @(posedge MCLK_I) disable iff (RST_I)
        s_wrap_quiet |-> s_roll_shown;
    endproperty
    a_roll_late: assert property (p_roll_late) // RULE10
        else $error("roll-over timing wrong");

    property p_hold;
        @(posedge MCLK_I) disable iff (RST_I)
        wr_timer |=> !timer_tick [*5];
    endproperty
    a_hold: assert property (p_hold) // RULE2
        else $error("increment not held after write");

    property p_sleep;
        @(posedge MCLK_I) disable iff (RST_I)
        sleep_r |-> !timer_tick && !wrap;
    endproperty
    a_sleep: assert property (p_sleep) // RULE9
        else $error("timer ran in sleep");

    property p_presc_clr;
        @(posedge MCLK_I) disable iff (RST_I)
        (wr_timer && assigned_timer) |=> presc_r == 8'h00;
    endproperty
    a_presc_clr: assert property (p_presc_clr) // RULE17
        else $error("prescaler not cleared by timer write");

    property p_wdt_clr;
        @(posedge MCLK_I) disable iff (RST_I)
        (wdt_clear_pulse && !assigned_timer) |=> presc_r == 8'h00;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) // RULE18
        else $error("prescaler not cleared by watchdog clear");

    property p_irq_mask;
        @(posedge MCLK_I) disable iff (RST_I)
        !int_control_r[tmz_pkg::INTC_OVERFLOW_INT_ENABLE] |=> !TIMER_IRQ_O;
    endproperty
    a_irq_mask: assert property (p_irq_mask) // RULE7
        else $error("masked interrupt raised");

    property p_flag_sticky;
        @(posedge MCLK_I) disable iff (RST_I)
        int_control_r[tmz_pkg::INTC_OVERFLOW_FLAG] && !wr_intc
            |=> int_control_r[tmz_pkg::INTC_OVERFLOW_FLAG];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // RULE8
        else $error("overflow flag cleared by hardware");

    property p_sample_phase;
        @(posedge MCLK_I) disable iff (RST_I)
        (phase_r == 2'(tmz_pkg::PH_Q1) || phase_r == 2'(tmz_pkg::PH_Q3))
            |=> $stable(samp_r);
    endproperty
    a_sample_phase: assert property (p_sample_phase) // RULE11
        else $error("sampling outside second and fourth phase");

    // one prescaler fall never gives two increments
    property p_tick_single;
        @(posedge MCLK_I) disable iff (RST_I)
        (assigned_timer && timer_tick) ##1 assigned_timer |-> !timer_tick;
    endproperty
    a_tick_single: assert property (p_tick_single) // RULE11
        else $error("prescaled tick counted twice");

    // the watchdog only sees prescaler ticks while it owns the prescaler
    property p_wdt_tick_owner;
        @(posedge MCLK_I) disable iff (RST_I)
        assigned_timer |=> !PRESCALER_TICK_WDT_O;
    endproperty
    a_wdt_tick_owner: assert property (p_wdt_tick_owner) // RULE16
        else $error("watchdog tick while prescaler on timer");
endmodule // tmz_timer0

/* File: sim/tmz_count_src.sv */
// external count pin source model
module tmz_count_src (
    input wire logic clk_i,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_o = 1'h0;
    // high two clocks, low two clocks: legal with or without prescaler
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'h1;
            repeat (2) @(posedge clk_i);
            pin_o <= 1'h0;
            @(posedge clk_i);
        end
    endtask
    task automatic set(input logic v);
        @(posedge clk_i);
        pin_o <= v;
    endtask
endmodule // tmz_count_src

/* File: sim/timer0_with_shared_prescaler_tb_top.sv */
// self-checking testbench for the timer0 block
module timer0_with_shared_prescaler_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic w;
        logic [7:0] i;
        logic [7:0] d;
        logic [7:0] e;
    } tmz_row_type;
    localparam logic [7:0] a_tc = tmz_pkg::IDX_TIMER_COUNT;
    localparam logic [7:0] a_ic = tmz_pkg::IDX_INT_CONTROL;
    localparam logic [7:0] a_op = tmz_pkg::IDX_OPTION;
    localparam logic [7:0] a_pa = tmz_pkg::IDX_PORT_A_DIR;
    localparam logic [7:0] a_ct = tmz_pkg::IDX_CONTROL;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic wdc = 1'h0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h1;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic ack, irq, tick, ext;
    logic [7:0] opt, a, b;
    logic [4:0] pad;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int ticks = 0;
    int rs[3] = '{0, 1, 7};
    tmz_row_type rows[11] = '{
        '{0, a_tc, 8'h00, tmz_pkg::RST_TIMER_COUNT},
        '{0, a_ic, 8'h00, tmz_pkg::RST_INT_CONTROL},
        '{0, a_op, 8'h00, tmz_pkg::RST_OPTION},
        '{0, a_pa, 8'h00, tmz_pkg::RST_PORT_A_DIR},
        '{0, 8'h7e, 8'h00, 8'h00},
        '{1, a_pa, 8'hea, 8'h00},
        '{0, a_pa, 8'h00, 8'h0a},
        '{1, a_op, 8'h55, 8'h00},
        '{0, a_op, 8'h00, 8'h55},
        '{1, a_ic, 8'h20, 8'h00},
        '{0, a_ic, 8'h00, 8'h20}};
    always #2.5 clk = ~clk;
    tmz_timer0 DUT (.MCLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(rd),
        .ACK_O(ack), .EXT_COUNT_I(ext), .WATCHDOG_CLEAR_I(wdc),
        .TIMER_IRQ_O(irq), .PRESCALER_TICK_WDT_O(tick), .OPTION_O(opt),
        .PORT_A_DIR_O(pad));
    tmz_count_src src (.clk_i(clk), .pin_o(ext));
    // the tick is a one-cycle pulse, so the negedge sees it exactly once
    always @(negedge clk) begin
        if (tick === 1'h1) ticks++;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    // the request stands until ack is seen high at a rising edge
    task automatic wb(input logic w, input logic [7:0] i,
        input logic [7:0] d, output logic [7:0] q);
        int n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {i, 2'h0};
        dat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'h1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) error_cnt++;
        q = rd[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        wb(1'h1, i, d, q);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] q;
        wb(1'h0, i, 8'h00, q);
        chk8($sformatf("reg %h", i), e, q);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // back-to-back accesses are taken 3+n edges apart after wt(n)
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        foreach (rows[k]) begin
            if (rows[k].w) wr(rows[k].i, rows[k].d);
            else rdc(rows[k].i, rows[k].e);
        end
        chk8("option port", 8'h55, opt);
        chk8("port a port", 8'h0a, {3'h0, pad});
        wr(a_tc, 8'h00);
        wr(a_ct, 8'h02);
        wr(a_op, 8'h08);
        wr(a_tc, 8'h40);
        rdc(a_tc, 8'h40);
        wr(a_tc, 8'h40);
        wt(6);
        rdc(a_tc, 8'h40);
        wr(a_tc, 8'h40);
        wt(10);
        rdc(a_tc, 8'h41);
        wb(1'h0, a_tc, 8'h00, a);
        wt(37);
        wb(1'h0, a_tc, 8'h00, b);
        chk8("count per 40 clocks", 8'h0a, b - a);
        wr(a_ic, 8'h00);
        wr(a_tc, 8'hfd);
        wt(40);
        rdc(a_ic, 8'h04);
        chk1("masked irq", 1'h0, irq);
        wr(a_ic, 8'h24);
        wt(3);
        @(negedge clk);
        chk1("irq", 1'h1, irq);
        wt(40);
        rdc(a_ic, 8'h24);
        wr(a_ic, 8'h20);
        rdc(a_ic, 8'h20);
        @(negedge clk);
        chk1("cleared irq", 1'h0, irq);
        wr(a_ct, 8'h01);
        wb(1'h0, a_tc, 8'h00, a);
        wt(37);
        wb(1'h0, a_tc, 8'h00, b);
        chk8("count in sleep", a, b);
        wr(a_ct, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr(a_op, s ? 8'h38 : 8'h28);
            wr(a_tc, 8'h00);
            wt(12);
            src.set(1'h1);
            wt(12);
            rdc(a_tc, s ? 8'h00 : 8'h01);
            src.set(1'h0);
            wt(12);
            rdc(a_tc, 8'h01);
        end
        wr(a_ct, 8'h02);
        foreach (rs[k]) begin
            wr(a_op, 8'h20 | 8'(rs[k]));
            wr(a_tc, 8'h00);
            wt(12);
            src.pulses(3 * (2 << rs[k]) - 1);
            wt(20);
            rdc(a_tc, 8'h02);
            src.pulses(1);
            wt(20);
            rdc(a_tc, 8'h03);
        end
        ticks = 0;
        wt(600);
        chk1("tick with timer", 1'h0, ticks > 0);
        wr(a_tc, 8'h00);
        wr(a_ct, 8'h02);
        wr(a_op, 8'h08);
        ticks = 0;
        wt(200);
        chk1("tick with watchdog", 1'h1, ticks > 0);
        // a clear every 100 clocks must keep the long ratio from ending
        wr(a_op, 8'h0f);
        wdc <= 1'h1;
        wt(50);
        wdc <= 1'h0;
        ticks = 0;
        repeat (12) begin
            wt(50);
            wdc <= 1'h1;
            wt(50);
            wdc <= 1'h0;
        end
        chk1("tick under clears", 1'h0, ticks > 0);
        wt(1100);
        chk1("tick without clears", 1'h1, ticks > 0);
        // mid-run reset brings registers and port copies back
        rst <= 1'h1;
        wt(8);
        rst <= 1'h0;
        chk8("option port after reset", tmz_pkg::RST_OPTION, opt);
        chk1("irq after reset", 1'h0, irq);
        rdc(a_tc, tmz_pkg::RST_TIMER_COUNT);
        rdc(a_op, tmz_pkg::RST_OPTION);
        conclude();
    end
endmodule // timer0_with_shared_prescaler_tb_top
